//--- hw/ratb_pkg.sv
// Package: constants and carriers for the register access type bank
package ratb_pkg;

  // Register offsets, added to the module base address
  localparam logic [11:0] RATB_OFS_CTRL   = 12'h000;  // R/W control
  localparam logic [11:0] RATB_OFS_STAT   = 12'h004;  // RO status
  localparam logic [11:0] RATB_OFS_EVRAW  = 12'h008;  // R/W1C event status
  localparam logic [11:0] RATB_OFS_EVCLR  = 12'h00C;  // W1C event clear
  localparam logic [11:0] RATB_OFS_EVCNT  = 12'h010;  // RC event counter
  localparam logic [11:0] RATB_OFS_CMD    = 12'h014;  // WO command

  // Field widths and positions
  localparam int          RATB_EV_W       = 8;
  localparam int          RATB_STAT_W     = 8;
  localparam int          RATB_CNT_W      = 8;
  localparam int          RATB_ID_LSB     = 16;

  // Reset values
  localparam logic [31:0] RATB_CTRL_RST   = 32'h0000_0101;
  localparam logic [7:0]  RATB_EV_RST     = 8'h00;
  localparam logic [7:0]  RATB_CNT_RST    = 8'h00;
  localparam logic [7:0]  RATB_STAT_RST   = 8'h00;
  localparam logic [31:0] RATB_CMD_RST    = 32'h0000_0000;
  localparam logic [31:0] RATB_RD_ZERO    = 32'h0000_0000;
  // Block identity code; the value is arbitrary
  localparam logic [7:0]  RATB_BLOCK_ID   = 8'h5A;

  // Bus answer phase
  typedef enum logic {RATB_PH_SETUP, RATB_PH_ANSWER} ratb_phase_t;

  // APB request from the bus master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ratb_apb_req_t;

  // APB answer to the bus master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ratb_apb_rsp_t;

endpackage : ratb_pkg

//--- hw/ratb_bank.sv
// Register bank with R/W, RO, RC, R/W1C, W1C and WO access types on APB
//
// Operation
// - A register is chosen by its offset from the module base address.
// - A clear-on-read field returns its value and is zeroed by hardware once the read completes.
// - A readable write-one-to-clear bit reads its status, clears on a written 1 and keeps on a written 0.
// - A write-only clear bit clears its target status on a written 1 and reads as nothing meaningful.
// - A write-only register takes writes only and its read data must not be relied on.
// - Every bit takes its reset value after any reset.
// - A bit with reset value zero is driven to 0 under chip reset.
// - A bit with reset value one is driven to 1 under chip reset.
// - Reserved bits read as zero and software does not depend on them.
`timescale 1ns/1ps

module ratb_bank
  import ratb_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire ratb_apb_req_t          apb_req,
  output ratb_apb_rsp_t               apb_rsp,
  input  wire logic [RATB_STAT_W-1:0] hw_status,
  input  wire logic [RATB_EV_W-1:0]   hw_event,
  output logic      [31:0]            ctrl_out,
  output logic      [31:0]            cmd_pulse,
  output logic                        cmd_strobe
);

  // Offset decode, shared by read mux and write strobes
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // Bus phase and answer registers
  ratb_phase_t              phase_q,  phase_d;
  ratb_apb_rsp_t            rsp_q,    rsp_d;
  // Storage of the bank
  logic [31:0]              ctrl_q,   ctrl_d;
  logic [RATB_STAT_W-1:0]   stat_q,   stat_d;
  logic [RATB_EV_W-1:0]     ev_q,     ev_d;
  logic [RATB_CNT_W-1:0]    cnt_q,    cnt_d;
  logic [31:0]              cmd_q,    cmd_d;
  logic                     cstb_q,   cstb_d;

  logic                     acc_start;
  logic                     acc_done;
  logic                     wr_done;
  logic                     rd_done;
  logic                     mapped;
  logic [31:0]              rd_mux;
  logic [RATB_EV_W-1:0]     ev_clr;
  logic                     any_event;

  // One wait state: answer is prepared in the first access cycle, ends the next
  assign acc_start = apb_req.psel && apb_req.penable && (phase_q == RATB_PH_SETUP);
  assign acc_done  = apb_req.psel && apb_req.penable && (phase_q == RATB_PH_ANSWER);
  assign wr_done   = acc_done && apb_req.pwrite && !rsp_q.pslverr;
  assign rd_done   = acc_done && !apb_req.pwrite && !rsp_q.pslverr;
  assign any_event = |hw_event;

  // Address map check; unmapped offsets answer with an error
  always_comb begin
    mapped = hit(apb_req.paddr, RATB_OFS_CTRL)  || hit(apb_req.paddr, RATB_OFS_STAT)  ||
             hit(apb_req.paddr, RATB_OFS_EVRAW) || hit(apb_req.paddr, RATB_OFS_EVCLR) ||
             hit(apb_req.paddr, RATB_OFS_EVCNT) || hit(apb_req.paddr, RATB_OFS_CMD);
  end

  // Read data mux; unused upper bits are reserved and read as zero
  always_comb begin
    rd_mux = RATB_RD_ZERO;
    if (hit(apb_req.paddr, RATB_OFS_CTRL)) begin
      rd_mux = ctrl_q;
    end else if (hit(apb_req.paddr, RATB_OFS_STAT)) begin
      rd_mux[RATB_STAT_W-1:0]             = stat_q;
      rd_mux[RATB_ID_LSB +: 8]            = RATB_BLOCK_ID;
    end else if (hit(apb_req.paddr, RATB_OFS_EVRAW)) begin
      rd_mux[RATB_EV_W-1:0]               = ev_q;
    end else if (hit(apb_req.paddr, RATB_OFS_EVCNT)) begin
      rd_mux[RATB_CNT_W-1:0]              = cnt_q;
    end else begin
      // Clear and command registers are write only: they read as zero
      rd_mux = RATB_RD_ZERO;
    end
  end

  // Bus phase and answer; data is sampled at the start so a clear-on-read shows the old value
  always_comb begin
    phase_d        = phase_q;
    rsp_d          = rsp_q;
    rsp_d.pready   = 1'b0;
    case (phase_q)
      RATB_PH_SETUP: begin
        if (acc_start) begin
          phase_d       = RATB_PH_ANSWER;
          rsp_d.pready  = 1'b1;
          rsp_d.pslverr = !mapped;
          rsp_d.prdata  = apb_req.pwrite ? RATB_RD_ZERO : rd_mux;
        end
      end
      RATB_PH_ANSWER: begin
        // Transfer ends here; master drops penable next cycle
        phase_d       = RATB_PH_SETUP;
        rsp_d.pslverr = 1'b0;
      end
      default: begin
        phase_d = RATB_PH_SETUP;
      end
    endcase
  end

  // Bus answer registers; an idle bank shows no ready and no error
  // Reset drops a transfer in flight, so the master must restart it after release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_q <= RATB_PH_SETUP;
      rsp_q   <= '{pready: 1'b0, pslverr: 1'b0, prdata: RATB_RD_ZERO};
    end else begin
      phase_q <= phase_d;
      rsp_q   <= rsp_d;
    end
  end

  // Control register: plain read/write word, whole word per access
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_done && hit(apb_req.paddr, RATB_OFS_CTRL)) begin
      ctrl_d = apb_req.pwdata;
    end
  end

  // Control storage; reset loads a mix of ones and zeros
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= RATB_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Status copy follows the hardware every cycle; bus writes never reach it
  always_comb begin
    stat_d = hw_status;
  end

  // Status storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_q <= RATB_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Event status: written ones clear, written zeros keep their bits
  always_comb begin
    ev_clr = '0;
    if (wr_done && (hit(apb_req.paddr, RATB_OFS_EVRAW) || hit(apb_req.paddr, RATB_OFS_EVCLR))) begin
      ev_clr = apb_req.pwdata[RATB_EV_W-1:0];
    end
    // Set wins so an event in the clearing cycle is never lost
    ev_d = (ev_q & ~ev_clr) | hw_event;
  end

  // Event status storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ev_q <= RATB_EV_RST;
    end else begin
      ev_q <= ev_d;
    end
  end

  // Event counter: one count per cycle with any event, saturating to hide overflow
  always_comb begin
    if (rd_done && hit(apb_req.paddr, RATB_OFS_EVCNT)) begin
      // Clear only at the completing edge, so a read clears once; a same-cycle event still counts
      cnt_d = any_event ? RATB_CNT_W'(1) : RATB_CNT_RST;
    end else if (any_event && (cnt_q != {RATB_CNT_W{1'b1}})) begin
      cnt_d = cnt_q + RATB_CNT_W'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  // Event counter storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= RATB_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Command word stands for one cycle with its strobe, otherwise idle
  always_comb begin
    cmd_d  = RATB_CMD_RST;
    cstb_d = 1'b0;
    if (wr_done && hit(apb_req.paddr, RATB_OFS_CMD)) begin
      cmd_d  = apb_req.pwdata;
      cstb_d = 1'b1;
    end
  end

  // Command storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_q  <= RATB_CMD_RST;
      cstb_q <= 1'b0;
    end else begin
      cmd_q  <= cmd_d;
      cstb_q <= cstb_d;
    end
  end

  // Outputs come straight from flip-flops
  assign apb_rsp    = rsp_q;
  assign ctrl_out   = ctrl_q;
  assign cmd_pulse  = cmd_q;
  assign cmd_strobe = cstb_q;

endmodule : ratb_bank

//--- verification/ratb_bank_assertions.sv
// Checker on the bus and output ports of the register bank
`timescale 1ns/1ps
module ratb_bank_assertions
  import ratb_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire ratb_apb_req_t apb_req,
  input wire ratb_apb_rsp_t apb_rsp,
  input wire logic [31:0]   ctrl_out,
  input wire logic [31:0]   cmd_pulse,
  input wire logic          cmd_strobe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Short views of the bus; rdy marks the completing edge
  wire        act = apb_req.psel & apb_req.penable;
  wire        rdy = apb_rsp.pready;
  wire        wr  = rdy & apb_req.pwrite;
  wire        rd  = rdy & ~apb_req.pwrite;
  wire [11:0] adr = apb_req.paddr;
  a_one_wait: assert property (act && !$past(act) |=> rdy)
    else $error("no pready after wait state");
  a_ready_pulse: assert property (rdy |-> act ##1 !rdy)
    else $error("pready not a single access pulse");
  a_ctrl_write: assert property (wr && adr == RATB_OFS_CTRL |=> ctrl_out == $past(apb_req.pwdata))
    else $error("ctrl write not applied");
  a_ctrl_hold: assert property (!(wr && adr == RATB_OFS_CTRL) |=> $stable(ctrl_out))
    else $error("ctrl changed without write");
  a_cmd_strobe: assert property (wr && adr == RATB_OFS_CMD |-> ##[1:2] cmd_strobe)
    else $error("no command strobe");
  a_cmd_quiet: assert property (!cmd_strobe |-> cmd_pulse == RATB_CMD_RST)
    else $error("command data outside strobe");
  a_map_error: assert property (rdy && adr > RATB_OFS_CMD |-> apb_rsp.pslverr)
    else $error("unmapped offset accepted");
  a_stat_rsvd: assert property (rd && adr == RATB_OFS_STAT |-> apb_rsp.prdata[31:8] == {8'h00, RATB_BLOCK_ID, 8'h00})
    else $error("status upper bits wrong");
endmodule : ratb_bank_assertions

bind ratb_bank ratb_bank_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .ctrl_out(ctrl_out), .cmd_pulse(cmd_pulse), .cmd_strobe(cmd_strobe));

//--- verification/ratb_apb_master.sv
// Processor-side bus master model issuing single APB transfers
`timescale 1ns/1ps
module ratb_apb_master
  import ratb_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire ratb_apb_rsp_t apb_rsp,
  output ratb_apb_req_t      apb_req
);
  initial apb_req = '0;
  // Setup, access, hold until pready; released lines show inverted values so stale data cannot pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    @(posedge clk_sys);
    #1 apb_req = '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    #1 apb_req.penable = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!apb_rsp.pready && n < 8);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr | ~apb_rsp.pready;
    #1 apb_req = '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask : xfer
endmodule : ratb_apb_master

//--- verification/ratb_bank_tb.sv
// Self-checking testbench for the register bank
`timescale 1ns/1ps
module ratb_bank_tb;
  import ratb_pkg::*;
  logic          clk_sys   = 1'b0;
  logic          rst_n     = 1'b0;
  logic [7:0]    hw_status = 8'h3C;
  logic [7:0]    hw_event  = 8'h00;
  logic [31:0]   ctrl_out, cmd_pulse, rd;
  logic          cmd_strobe, err;
  ratb_apb_req_t apb_req;
  ratb_apb_rsp_t apb_rsp;
  int            num_errors = 0, checks = 0, cyc = 0;
  // 10 MHz clock; a hang ends the run after a cycle ceiling
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  ratb_bank uut (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .hw_status(hw_status),
    .hw_event(hw_event), .ctrl_out(ctrl_out), .cmd_pulse(cmd_pulse), .cmd_strobe(cmd_strobe));
  ratb_apb_master m (.clk_sys(clk_sys), .apb_rsp(apb_rsp), .apb_req(apb_req));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One access; read data is judged on reads only since writes answer zero
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic x);
    m.xfer(w, a, d, rd, err);
    if (!w) chk("prdata", e, rd);
    chk("pslverr", 32'(x), 32'(err));
  endtask : acc
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
  endtask : do_reset
  task automatic t_reset;
    chk("ctrl_out", RATB_CTRL_RST, ctrl_out);
    chk("cmd_pulse", RATB_CMD_RST, cmd_pulse);
    chk("cmd_strobe", 32'h0000_0000, 32'(cmd_strobe));
    acc(1'b0, RATB_OFS_CTRL, '0, RATB_CTRL_RST, 1'b0);
    acc(1'b0, RATB_OFS_EVRAW, '0, '0, 1'b0);
    acc(1'b0, RATB_OFS_EVCNT, '0, '0, 1'b0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_rw;
    logic [31:0] s;
    s = {8'h00, RATB_BLOCK_ID, 8'h00, hw_status};
    acc(1'b1, RATB_OFS_CTRL, 32'hA5A5_5A5A, '0, 1'b0);
    chk("ctrl_out", 32'hA5A5_5A5A, ctrl_out);
    acc(1'b0, RATB_OFS_CTRL, '0, 32'hA5A5_5A5A, 1'b0);
    acc(1'b0, RATB_OFS_STAT, '0, s, 1'b0);
    acc(1'b1, RATB_OFS_STAT, s, '0, 1'b0);
    acc(1'b0, RATB_OFS_STAT, '0, s, 1'b0);
    $display("read write test done");
  endtask : t_rw
  task automatic t_ev;
    @(posedge clk_sys);
    #1 hw_event = 8'hA5;
    @(posedge clk_sys);
    #1 hw_event = 8'h00;
    acc(1'b0, RATB_OFS_EVRAW, '0, 32'h0000_00A5, 1'b0);
    acc(1'b0, RATB_OFS_EVCNT, '0, 32'h0000_0001, 1'b0);
    acc(1'b0, RATB_OFS_EVCNT, '0, '0, 1'b0);
    acc(1'b1, RATB_OFS_EVRAW, 32'h0000_0005, '0, 1'b0);
    acc(1'b0, RATB_OFS_EVRAW, '0, 32'h0000_00A0, 1'b0);
    acc(1'b1, RATB_OFS_EVCLR, 32'h0000_0080, '0, 1'b0);
    acc(1'b0, RATB_OFS_EVRAW, '0, 32'h0000_0020, 1'b0);
    acc(1'b0, RATB_OFS_EVCLR, '0, '0, 1'b0);
    $display("event test done");
  endtask : t_ev
  task automatic t_cmd;
    acc(1'b1, RATB_OFS_CMD, 32'h1234_5678, '0, 1'b0);
    chk("cmd_pulse", 32'h1234_5678, cmd_pulse);
    chk("cmd_strobe", 32'h0000_0001, 32'(cmd_strobe));
    acc(1'b0, RATB_OFS_CMD, '0, '0, 1'b0);
    chk("cmd_pulse", RATB_CMD_RST, cmd_pulse);
    chk("cmd_strobe", 32'h0000_0000, 32'(cmd_strobe));
    acc(1'b1, 12'h100, 32'hFFFF_FFFF, '0, 1'b1);
    acc(1'b0, RATB_OFS_CTRL, '0, 32'hA5A5_5A5A, 1'b0);
    $display("command test done");
  endtask : t_cmd
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Second reset after the command test proves the reset values return
  initial begin
    do_reset();
    t_reset();
    t_rw();
    t_ev();
    t_cmd();
    do_reset();
    t_reset();
    end_sim();
  end
endmodule : ratb_bank_tb
